// file: src/drt_timers.sv
`timescale 1ns/1ps
// Contract
// R1: Second timer is an 8-bit down counter with its own preset buffer.
// R2: Third timer is an 8-bit down counter with its own preset buffer.
// R3: Second timer run bit 1 runs it, 0 stops it.
// R4: In PWM mode the first timer run bit starts and stops the second timer.
// R5: Third timer run bit 1 makes it count, 0 halts it.
// R6: Second timer load bit 1: preset write also loads the counter.
// R7: Third timer load bit likewise; acts only at a preset write.
// R8: Underflow reloads the counter from the preset regardless of load bit.
// R9: Second timer source: pin, instruction clock, oscillator, twice oscillator.
// R10: Third timer source: pin, instruction clock, oscillator; code 11 unused.
// R11: Second timer edge bit: 0 rising, 1 falling pin edges.
// R12: Third timer edge bit: 1 falling, 0 rising pin edges.
// R13: Edge bit matters only while the pin is the selected source.
// R14: Second timer prescaler divides by two to the field value, 1 to 128.
// R15: Third timer prescaler divides by two to the field value, 1 to 128.
// R16: Second timer underflow sets its sticky flag until software clears it.
// R17: Third timer underflow sets its sticky flag until software clears it.
// R18: Each prescaler pulse decrements by one; decrement from zero underflows.
// R19: Changing prescale or source restarts that prescaler from zero.
module drt_timers
#(
  parameter int INSTR_DIV = drt_pkg::INSTR_DIV_DEFAULT
)
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire drt_pkg::drt_bus_type bus,
  input  wire logic                 external_count_clock_pin,
  input  wire logic                 pwm_mode,
  input  wire logic                 first_timer_run,
  output logic [7:0]                read_data,
  output logic                      irq,
  output logic [1:0]                underflow_pulse
);
  import drt_pkg::*;

  // Index 0 is the second timer, index 1 the third timer
  drt_ctrl_type ctrl     [2];
  logic [7:0]   preset   [2];
  logic [7:0]   counter  [2];
  logic [6:0]   pre_cnt  [2];
  logic [1:0]   status;
  logic [1:0]   enable;
  logic         fosc_en;
  logic [7:0]   instr_cnt;
  logic         instr_en;
  logic         pin_prev;
  logic         pin_rise;
  logic         pin_fall;
  logic [1:0]   wr_ctrl;
  logic [1:0]   wr_preset;
  logic [1:0]   fld_change;
  logic [1:0]   run;
  logic [1:0]   src_tick;
  logic [1:0]   pre_done;
  logic [1:0]   cnt_tick;
  logic [1:0]   uf_set;
  logic [1:0]   next_status;
  logic [1:0]   next_enable;
  drt_ctrl_type wr_fields;

  function automatic logic [6:0] prescale_mask(input logic [2:0] ps);
    logic [7:0] full;
    full = (8'h01 << ps) - 8'h01;
    return full[6:0];
  endfunction

  function automatic logic select_tick(input logic [1:0] src,
                                       input logic       edge_sel,
                                       input logic       allow_double,
                                       input logic       rise,
                                       input logic       fall,
                                       input logic       instr,
                                       input logic       fosc);
    logic t;
    t = 1'b0;
    unique case (src)
      SRC_PIN:   t = edge_sel ? fall : rise;  // see R11, see R12, see R13
      SRC_INSTR: t = instr;
      SRC_FOSC:  t = fosc;
      SRC_FOSC2: t = allow_double;
    endcase
    return t;
  endfunction

  assign wr_fields = drt_ctrl_type'(bus.wdata);
  assign pin_rise  = external_count_clock_pin & ~pin_prev;
  assign pin_fall  = ~external_count_clock_pin & pin_prev;
  assign instr_en  = fosc_en && (instr_cnt == 8'(INSTR_DIV - 1));

  // clk stands for twice the oscillator rate; slower rates are enables
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fosc_en   <= 1'b0;
      instr_cnt <= 8'h00;
    end
    else
    begin
      fosc_en <= ~fosc_en;
      if (fosc_en)
      begin
        instr_cnt <= instr_en ? 8'h00 : instr_cnt + 8'h01;
      end
    end
  end

  // Pin is already synchronous, one stage is enough for edge detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_prev <= external_count_clock_pin;
    end
  end

  always_comb
  begin
    wr_ctrl[0]   = bus.wr && bus.addr == OFF_T2_CTRL;
    wr_ctrl[1]   = bus.wr && bus.addr == OFF_T3_CTRL;
    wr_preset[0] = bus.wr && bus.addr == OFF_T2_PRESET;
    wr_preset[1] = bus.wr && bus.addr == OFF_T3_PRESET;
    run[0] = pwm_mode ? first_timer_run : ctrl[0].run;  // see R3, see R4
    run[1] = ctrl[1].run;  // see R5
    for (int i = 0; i < 2; i++)
    begin
      fld_change[i] = wr_ctrl[i] && (wr_fields.source != ctrl[i].source
                                  || wr_fields.prescale != ctrl[i].prescale);
      // Code 11 gives no tick on the third timer, see R10
      src_tick[i] = select_tick(ctrl[i].source, ctrl[i].edge_sel, i == 0,
                                pin_rise, pin_fall, instr_en, fosc_en);  // see R9, see R11
      pre_done[i] = pre_cnt[i] == prescale_mask(ctrl[i].prescale);  // see R14, see R15
      cnt_tick[i] = run[i] && src_tick[i] && pre_done[i];  // see R18
      uf_set[i]   = cnt_tick[i] && counter[i] == 8'h00;  // see R18
    end
    next_status = (status & ~((bus.wr && bus.addr == OFF_INT_CLEAR) ? bus.wdata[1:0] : 2'h0))
                  | uf_set;  // see R16, see R17
    next_enable = (bus.wr && bus.addr == OFF_INT_EN) ? bus.wdata[1:0] : enable;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
      begin
        ctrl[i]   <= drt_ctrl_type'(CTRL_RESET);
        preset[i] <= PRESET_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_ctrl[i])
        begin
          ctrl[i] <= wr_fields;
        end
        if (wr_preset[i])
        begin
          preset[i] <= bus.wdata;  // see R1, see R2
        end
      end
    end
  end

  // Prescaler stalls while the timer is stopped, keeping its phase
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
      begin
        pre_cnt[i] <= 7'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (fld_change[i])
        begin
          pre_cnt[i] <= 7'h00;  // see R19
        end
        else if (run[i] && src_tick[i])
        begin
          pre_cnt[i] <= pre_done[i] ? 7'h00 : pre_cnt[i] + 7'h01;  // see R14, see R15
        end
      end
    end
  end

  // A load-on-write beats a tick in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
      begin
        counter[i] <= COUNT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_preset[i] && ctrl[i].load_on_write)
        begin
          counter[i] <= bus.wdata;  // see R6, see R7
        end
        else if (cnt_tick[i])
        begin
          counter[i] <= (counter[i] == 8'h00) ? preset[i] : counter[i] - 8'h01;  // see R8
        end
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      status          <= INT_RESET;
      enable          <= INT_RESET;
      irq             <= 1'b0;
      underflow_pulse <= 2'h0;
    end
    else
    begin
      status          <= next_status;  // see R16, see R17
      enable          <= next_enable;
      irq             <= |(next_status & next_enable);
      underflow_pulse <= uf_set;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      read_data <= 8'h00;
    end
    else if (bus.rd)
    begin
      unique case (bus.addr)
        OFF_T2_CTRL:   read_data <= ctrl[0];
        OFF_T2_PRESET: read_data <= preset[0];
        OFF_T3_CTRL:   read_data <= ctrl[1];
        OFF_T3_PRESET: read_data <= preset[1];
        OFF_T2_COUNT:  read_data <= counter[0];
        OFF_T3_COUNT:  read_data <= counter[1];
        OFF_INT_STAT:  read_data <= {6'h00, status};
        OFF_INT_EN:    read_data <= {6'h00, enable};
        default:       read_data <= 8'h00;
      endcase
    end
    else
    begin
      read_data <= 8'h00;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : gen_check
    sequence s_underflow;
      uf_set[g] && !wr_preset[g];
    endsequence

    sequence s_plain_tick;
      cnt_tick[g] && counter[g] != 8'h00 && !wr_preset[g];
    endsequence

    property p_reload;
      @(posedge clk) disable iff (reset)
      s_underflow |=> counter[g] == $past(preset[g]);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload on underflow");  // see R8

    property p_decrement;
      @(posedge clk) disable iff (reset)
      s_plain_tick |=> counter[g] == $past(counter[g]) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("bad decrement");  // see R18

    property p_load_write;
      @(posedge clk) disable iff (reset)
      wr_preset[g] && ctrl[g].load_on_write |=> counter[g] == $past(bus.wdata);
    endproperty
    a_load_write: assert property (p_load_write) else $error("no load on write");  // see R6

    property p_no_load;
      @(posedge clk) disable iff (reset)
      wr_preset[g] && !ctrl[g].load_on_write && !cnt_tick[g] |=> $stable(counter[g]);
    endproperty
    a_no_load: assert property (p_no_load) else $error("counter changed on write");  // see R7

    property p_halt;
      @(posedge clk) disable iff (reset)
      !run[g] && !wr_preset[g] |=> $stable(counter[g]);
    endproperty
    a_halt: assert property (p_halt) else $error("stopped timer moved");  // see R5

    property p_flag;
      @(posedge clk) disable iff (reset)
      uf_set[g] |=> status[g] && underflow_pulse[g];
    endproperty
    a_flag: assert property (p_flag) else $error("underflow flag not set");  // see R16

    property p_restart;
      @(posedge clk) disable iff (reset)
      fld_change[g] |=> pre_cnt[g] == 7'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("prescaler not restarted");  // see R19

    property p_edge;
      @(posedge clk) disable iff (reset)
      ctrl[g].source == SRC_PIN |-> src_tick[g] == (ctrl[g].edge_sel ? pin_fall : pin_rise);
    endproperty
    a_edge: assert property (p_edge) else $error("wrong pin edge");  // see R11
  end

  property p_pwm_run;
    @(posedge clk) disable iff (reset)
    pwm_mode |-> run[0] == first_timer_run;
  endproperty
  a_pwm_run: assert property (p_pwm_run) else $error("pwm run source wrong");  // see R4

  property p_src3_off;
    @(posedge clk) disable iff (reset)
    ctrl[1].source == SRC_FOSC2 |-> !cnt_tick[1];
  endproperty
  a_src3_off: assert property (p_src3_off) else $error("unused source ticked");  // see R10

  property p_fosc2;
    @(posedge clk) disable iff (reset)
    ctrl[0].source == SRC_FOSC2 && ctrl[0].prescale == 3'h0 && run[0] |-> cnt_tick[0];
  endproperty
  a_fosc2: assert property (p_fosc2) else $error("fast source missed");  // see R9

  property p_irq;
    @(posedge clk) disable iff (reset)
    irq == |(status & enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");  // see R17

  property p_read_count;
    @(posedge clk) disable iff (reset)
    bus.rd && bus.addr == OFF_T2_COUNT |=> read_data == $past(counter[0]);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count readback wrong");  // see R1

endmodule

// file: src/drt_pkg.sv
package drt_pkg;

  // Register offsets as seen on the plain register port
  localparam logic [7:0] OFF_T2_CTRL   = 8'h0f;
  localparam logic [7:0] OFF_T2_PRESET = 8'h10;
  localparam logic [7:0] OFF_T3_CTRL   = 8'h22;
  localparam logic [7:0] OFF_T3_PRESET = 8'h24;
  localparam logic [7:0] OFF_T2_COUNT  = 8'h30;
  localparam logic [7:0] OFF_T3_COUNT  = 8'h31;
  localparam logic [7:0] OFF_INT_STAT  = 8'h32;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h33;
  localparam logic [7:0] OFF_INT_EN    = 8'h34;

  // Reset values
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] PRESET_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [1:0] INT_RESET     = 2'h0;

  // Count source codes
  localparam logic [1:0] SRC_PIN   = 2'h0;
  localparam logic [1:0] SRC_INSTR = 2'h1;
  localparam logic [1:0] SRC_FOSC  = 2'h2;
  localparam logic [1:0] SRC_FOSC2 = 2'h3;

  // Instruction cycle length in oscillator periods
  localparam int INSTR_DIV_DEFAULT = 4;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       run;
    logic       load_on_write;
    logic [1:0] source;
    logic       edge_sel;
    logic [2:0] prescale;
  } drt_ctrl_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } drt_bus_type;

endpackage

// file: tb/drt_timers_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module drt_timers_tb_top;
  import drt_pkg::*;
  // Short instruction clock keeps slow sources cheap to run
  localparam int DIV = 2;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  drt_bus_type bus = '0;
  logic        pin = 1'b0;
  logic        pwm_mode = 1'b0;
  logic        first_timer_run = 1'b0;
  logic [7:0]  read_data;
  logic        irq;
  logic [1:0]  underflow_pulse;
  logic [7:0]  rv;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          stat = 0;
  int          en = 0;
  int          n;
  logic [7:0]  regs[$] = '{OFF_T2_CTRL, OFF_T2_PRESET, OFF_T3_CTRL, OFF_T3_PRESET,
                           OFF_T2_COUNT, OFF_T3_COUNT, OFF_INT_STAT, OFF_INT_EN, 8'h40};

  always #25 clk = ~clk;

  drt_timers #(.INSTR_DIV(DIV)) i_drt_timers
  (
    .clk                      (clk),
    .reset                    (reset),
    .bus                      (bus),
    .external_count_clock_pin (pin),
    .pwm_mode                 (pwm_mode),
    .first_timer_run          (first_timer_run),
    .read_data                (read_data),
    .irq                      (irq),
    .underflow_pulse          (underflow_pulse)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    if (a == OFF_INT_CLEAR)
      stat = stat & ~int'(d[1:0]);
    if (a == OFF_INT_EN)
      en = int'(d[1:0]);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 rv = read_data;
    `CHK("read_data", ex, rv)
  endtask

  // Irq is registered, so give it a spare edge before looking
  task automatic irqchk();
    repeat (2) @(posedge clk);
    #1 `CHK("irq", 1'((stat & en) != 0), irq)
  endtask

  task automatic gap(input int idx, input int lim, output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      // Busy pin proves a non-pin source ignores it and its edge bit
      pin <= ~pin;
      k++;
    end
    while (underflow_pulse[idx] !== 1'b1 && k < lim);
  endtask

  task automatic period(input int idx, input logic [1:0] src, input logic [2:0] ps,
                        input logic edg, input logic [7:0] pa, input logic [7:0] pb);
    logic [7:0] c;
    logic [7:0] p;
    logic [7:0] k;
    int         d;
    c = idx ? OFF_T3_CTRL : OFF_T2_CTRL;
    p = idx ? OFF_T3_PRESET : OFF_T2_PRESET;
    k = idx ? OFF_T3_COUNT : OFF_T2_COUNT;
    d = (src == SRC_FOSC2) ? 1 : (src == SRC_FOSC) ? 2 : 2 * DIV;
    wr(c, {2'b01, src, edg, ps});
    wr(p, pa);
    repeat (30) @(posedge clk);
    rdchk(k, pa);
    wr(c, {2'b00, src, edg, ps});
    wr(p, pb);
    rdchk(k, pa);
    rdchk(c, {2'b00, src, edg, ps});
    wr(c, {2'b10, src, edg, ps});
    gap(idx, 5000, n);
    gap(idx, 5000, n);
    `CHK("period", (int'(pb) + 1) * (1 << ps) * d, n)
    wr(c, 8'h00);
    stat = stat | (1 << idx);
  endtask

  task automatic pinchk(input int idx, input logic edg);
    logic [7:0] c;
    int         hi;
    int         lo;
    c = idx ? OFF_T3_CTRL : OFF_T2_CTRL;
    hi = 0;
    lo = 0;
    // Earlier gaps may leave the pin high, so start from a known low
    pin <= 1'b0;
    wr(c, {2'b01, SRC_PIN, edg, 3'h0});
    wr(idx ? OFF_T3_PRESET : OFF_T2_PRESET, 8'h00);
    wr(c, {2'b10, SRC_PIN, edg, 3'h0});
    repeat (3)
    begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (6)
      begin
        @(posedge clk);
        hi += int'(underflow_pulse[idx]);
      end
      pin <= 1'b0;
      repeat (6)
      begin
        @(posedge clk);
        lo += int'(underflow_pulse[idx]);
      end
    end
    `CHK("rise_count", edg ? 0 : 3, hi)
    `CHK("fall_count", edg ? 3 : 0, lo)
    wr(c, 8'h00);
    stat = stat | (1 << idx);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #(50 * 80000);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(43569));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (regs[i])
      rdchk(regs[i], 8'h00);
    for (int i = 0; i < 8; i++)
      period(i % 2, (i % 2) ? 2'($urandom_range(1, 2)) : 2'($urandom_range(1, 3)),
             (i == 1) ? 3'h7 : (i == 0) ? 3'h0 : 3'($urandom_range(0, 4)),
             1'($urandom_range(0, 1)), 8'($urandom_range(0, 5)), 8'($urandom_range(0, 5)));
    for (int i = 0; i < 4; i++)
      pinchk(i / 2, 1'(i % 2));
    // Own run bit clear: only the first timer's run bit may start it
    wr(OFF_T2_CTRL, {2'b01, SRC_FOSC2, 1'b0, 3'h0});
    wr(OFF_T2_PRESET, 8'h03);
    @(posedge clk);
    pwm_mode <= 1'b1;
    first_timer_run <= 1'b1;
    gap(0, 100, n);
    gap(0, 100, n);
    `CHK("pwm_period", 4, n)
    first_timer_run <= 1'b0;
    wr(OFF_T2_CTRL, {2'b10, SRC_FOSC2, 1'b0, 3'h0});
    repeat (4) @(posedge clk);
    gap(0, 60, n);
    `CHK("pwm_stopped", 60, n)
    pwm_mode <= 1'b0;
    wr(OFF_T2_CTRL, 8'h00);
    rdchk(OFF_INT_STAT, 8'(stat));
    irqchk();
    wr(OFF_INT_STAT, 8'h00);
    rdchk(OFF_INT_STAT, 8'(stat));
    wr(OFF_INT_EN, 8'h02);
    irqchk();
    wr(OFF_INT_CLEAR, 8'h02);
    rdchk(OFF_INT_STAT, 8'(stat));
    irqchk();
    wr(OFF_INT_EN, 8'h03);
    irqchk();
    wr(OFF_INT_CLEAR, 8'h03);
    rdchk(OFF_INT_STAT, 8'h00);
    irqchk();
    give_verdict();
  end
endmodule
